// ===== hw/sos_top.sv
// State output selector: two configurable state outputs behind APB.
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none

module sos_top #(
  parameter int FREQ_W = sos_pkg::FREQ_W // Motor frequency width.
) (
  input wire logic REF_CLK,                  // System clock, 20 MHz.
  input wire logic RST,                      // Synchronous reset, high.
  input wire logic PSEL,                     // APB select.
  input wire logic PENABLE,                  // APB enable.
  input wire logic PWRITE,                   // APB direction.
  input wire logic [7:0] PADDR,              // APB byte address.
  input wire logic [31:0] PWDATA,            // APB write data.
  output logic [31:0] PRDATA,                // APB read data.
  output logic PREADY,                       // APB ready.
  output logic PSLVERR,                      // APB error.
  input wire logic [5:0] SAFE_IN,            // Safe input pins one to six.
  input wire logic SAFETY_OUT_LEVEL,         // Dual-channel safety output.
  input wire logic ERR_CLASS2,               // Error class 2 present.
  input wire logic ERR_CLASS3,               // Error class 3 present.
  input wire logic ERR_CLASS4,               // Error class 4 present.
  input wire logic TORQUE_OFF,               // Internal torque-off state.
  input wire logic SUPPLY_MONITOR,           // Supply-monitor state.
  input wire logic [FREQ_W-1:0] MOTOR_FREQ,  // Motor frequency.
  input wire logic LIMITED_SPEED_ASSIGNED,   // Limited-speed set up.
  input wire logic OPEN_LOOP,                // Open-loop motor control.
  input wire logic POWER_STAGE_ON,           // Power stage enabled.
  output logic STATE_OUTPUT_A,               // State output A.
  output logic STATE_OUTPUT_B,               // State output B.
  output logic FREQ_NOT_MEANINGFUL,          // Frequency compare invalid.
  output logic IRQ                           // Level interrupt.
);

  ////////////////////////////////////////////////////////////////////////
  // Elaboration checks.

  // The state register packs the frequency into its upper half word.
  if (FREQ_W < 1 || FREQ_W > 16) begin : g_bad_width
    $error("FREQ_W must lie between 1 and 16");
  end

  ////////////////////////////////////////////////////////////////////////
  // State of the module.

  typedef struct packed {
    logic [4:0] sel_a;
    logic [4:0] sel_b;
    logic [FREQ_W-1:0] thresh;
    logic [3:0] status;
    logic [3:0] enable;
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic out_a_d;
    logic out_b_d;
    logic not_meaningful;
    logic [31:0] rdata;
    logic slverr;
  } sos_state_s;

  sos_state_s s_r;
  sos_state_s s_nxt;

  logic out_a;
  logic out_b;
  logic [FREQ_W-1:0] mon_freq;
  logic freq_below;
  logic [sos_pkg::STATE_W-1:0] state_vec;
  logic setup;
  logic wr;
  logic [3:0] ev;
  logic [31:0] rd_mux;
  logic rd_err;

  ////////////////////////////////////////////////////////////////////////
  // Helpers.

  // A source code is accepted when it exists and, for the frequency
  // comparison, when the limited-speed function has been set up.
  function automatic logic code_ok(input logic [4:0] code,
                                   input logic assigned);
    logic ok;
    ok = (code <= sos_pkg::SRC_FREQ_BELOW_LO);
    if (code == sos_pkg::SRC_FREQ_BELOW_LO && !assigned) begin
      ok = 1'b0;
    end
    return ok;
  endfunction

  // True when the address selects the word at this offset, write or not.
  function automatic logic hit(input logic [7:0] addr,
                               input logic [7:0] reg_addr);
    return addr == reg_addr;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Internal states offered to the outputs.

  // With open loop and the power stage off the measured frequency is
  // forced to zero; the comparison still runs but is flagged as invalid.
  always_comb begin
    if (OPEN_LOOP && !POWER_STAGE_ON) begin
      mon_freq = '0;
    end else begin
      mon_freq = MOTOR_FREQ;
    end
  end

  // The comparison runs whether or not limited speed is active.
  assign freq_below = mon_freq < s_r.thresh;

  // Safe inputs come from pins and are read only after the synchroniser.
  always_comb begin
    state_vec = '0;
    state_vec[sos_pkg::IDX_IN0 +: sos_pkg::IN_N] = s_r.sync2;
    state_vec[sos_pkg::IDX_SAFE_OUT] = SAFETY_OUT_LEVEL;
    state_vec[sos_pkg::IDX_ERR2] = ERR_CLASS2;
    state_vec[sos_pkg::IDX_ERR3] = ERR_CLASS3;
    state_vec[sos_pkg::IDX_ERR4] = ERR_CLASS4;
    state_vec[sos_pkg::IDX_TORQUE_OFF] = TORQUE_OFF;
    state_vec[sos_pkg::IDX_SUPPLY] = SUPPLY_MONITOR;
    state_vec[sos_pkg::IDX_FREQ_BELOW] = freq_below;
  end

  ////////////////////////////////////////////////////////////////////////
  // The two outputs, each with its own selection.

  // Output A.
  sos_output_mux u_mux_a (
    .clk(REF_CLK),
    .rst(RST),
    .sel(s_r.sel_a),
    .state(state_vec),
    .pin_out(out_a)
  );

  // Output B.
  sos_output_mux u_mux_b (
    .clk(REF_CLK),
    .rst(RST),
    .sel(s_r.sel_b),
    .state(state_vec),
    .pin_out(out_b)
  );

  ////////////////////////////////////////////////////////////////////////
  // APB decode.

  // Read data is latched in the setup cycle, so every access takes one
  // access cycle with PREADY high; this keeps PRDATA on a flip-flop.
  assign setup = PSEL && !PENABLE;
  assign wr = PSEL && PENABLE && PWRITE;

  // Read mux; unmapped offsets read zero and answer with an error.
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    unique case (PADDR)
      sos_pkg::ADDR_SEL_A: rd_mux[4:0] = s_r.sel_a;
      sos_pkg::ADDR_SEL_B: rd_mux[4:0] = s_r.sel_b;
      sos_pkg::ADDR_STATUS: rd_mux[3:0] = s_r.status;
      sos_pkg::ADDR_CLEAR: rd_mux = 32'h0000_0000;
      sos_pkg::ADDR_ENABLE: rd_mux[3:0] = s_r.enable;
      sos_pkg::ADDR_THRESH: rd_mux[FREQ_W-1:0] = s_r.thresh;
      sos_pkg::ADDR_STATE: begin
        rd_mux[sos_pkg::ST_OUT_A] = out_a;
        rd_mux[sos_pkg::ST_OUT_B] = out_b;
        rd_mux[sos_pkg::ST_NOT_MEANINGFUL] = s_r.not_meaningful;
        rd_mux[sos_pkg::ST_IN_LSB +: sos_pkg::IN_N] = s_r.sync2;
        rd_mux[sos_pkg::ST_FREQ_LSB +: FREQ_W] = mon_freq;
      end
      default: rd_err = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Events.

  // A refused selection is an event, as is every change of an output.
  always_comb begin
    ev = '0;
    ev[sos_pkg::EV_REJECT_A] = wr && hit(PADDR, sos_pkg::ADDR_SEL_A) &&
      !code_ok(PWDATA[4:0], LIMITED_SPEED_ASSIGNED);
    ev[sos_pkg::EV_REJECT_B] = wr && hit(PADDR, sos_pkg::ADDR_SEL_B) &&
      !code_ok(PWDATA[4:0], LIMITED_SPEED_ASSIGNED);
    ev[sos_pkg::EV_CHANGE_A] = out_a != s_r.out_a_d;
    ev[sos_pkg::EV_CHANGE_B] = out_b != s_r.out_b_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    s_nxt = s_r;
    // Two-stage synchroniser for the safe input pins.
    s_nxt.sync1 = SAFE_IN;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.out_a_d = out_a;
    s_nxt.out_b_d = out_b;
    s_nxt.not_meaningful = OPEN_LOOP && !POWER_STAGE_ON;
    // Capture the answer in the setup cycle.
    if (setup) begin
      s_nxt.rdata = PWRITE ? 32'h0000_0000 : rd_mux;
      s_nxt.slverr = rd_err;
    end
    // A refused code leaves the old selection in place.
    if (wr && hit(PADDR, sos_pkg::ADDR_SEL_A) &&
        code_ok(PWDATA[4:0], LIMITED_SPEED_ASSIGNED)) begin
      s_nxt.sel_a = PWDATA[4:0];
    end
    if (wr && hit(PADDR, sos_pkg::ADDR_SEL_B) &&
        code_ok(PWDATA[4:0], LIMITED_SPEED_ASSIGNED)) begin
      s_nxt.sel_b = PWDATA[4:0];
    end
    if (wr && hit(PADDR, sos_pkg::ADDR_ENABLE)) begin
      s_nxt.enable = PWDATA[3:0];
    end
    if (wr && hit(PADDR, sos_pkg::ADDR_THRESH)) begin
      s_nxt.thresh = PWDATA[FREQ_W-1:0];
    end
    // A new event in the same cycle as its clear survives the clear.
    if (wr && hit(PADDR, sos_pkg::ADDR_CLEAR)) begin
      s_nxt.status = (s_r.status & ~PWDATA[3:0]) | ev;
    end else begin
      s_nxt.status = s_r.status | ev;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register.

  // Configuration returns to the unused setting, so both outputs sit low.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      s_r <= '0;
      s_r.sel_a <= sos_pkg::SEL_RST;
      s_r.sel_b <= sos_pkg::SEL_RST;
      s_r.thresh <= sos_pkg::THRESH_RST[FREQ_W-1:0];
      s_r.status <= sos_pkg::EV_RST;
      s_r.enable <= sos_pkg::EV_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign PREADY = PSEL && PENABLE;
  assign PRDATA = s_r.rdata;
  assign PSLVERR = PSEL && PENABLE && s_r.slverr;
  assign STATE_OUTPUT_A = out_a;
  assign STATE_OUTPUT_B = out_b;
  assign FREQ_NOT_MEANINGFUL = s_r.not_meaningful;
  // The interrupt is a level that stays while any enabled bit is set.
  assign IRQ = |(s_r.status & s_r.enable);

endmodule

`default_nettype wire

// ===== hw/sos_pkg.sv
// Shared constants, codes and register map of the state output selector.
package sos_pkg;

  // Widths that more than one file relies on.
  localparam int SEL_W = 5;
  localparam int FREQ_W = 16;
  localparam int EV_W = 4;
  localparam int IN_N = 6;
  localparam int STATE_W = 13;
  localparam int APB_AW = 8;

  // Source codes of a state output, in the documented order.
  typedef enum logic [4:0] {
    SRC_NONE = 5'h00,
    SRC_IN1_HI = 5'h01,
    SRC_IN2_HI = 5'h02,
    SRC_IN3_HI = 5'h03,
    SRC_IN4_HI = 5'h04,
    SRC_IN5_HI = 5'h05,
    SRC_IN6_HI = 5'h06,
    SRC_IN1_LO = 5'h07,
    SRC_IN2_LO = 5'h08,
    SRC_IN3_LO = 5'h09,
    SRC_IN4_LO = 5'h0a,
    SRC_IN5_LO = 5'h0b,
    SRC_IN6_LO = 5'h0c,
    SRC_SAFE_OUT_LO = 5'h0d,
    SRC_SAFE_OUT_HI = 5'h0e,
    SRC_ERR2_HI = 5'h0f,
    SRC_ERR3_HI = 5'h10,
    SRC_ERR4_HI = 5'h11,
    SRC_ERR2_LO = 5'h12,
    SRC_ERR3_LO = 5'h13,
    SRC_ERR4_LO = 5'h14,
    SRC_TORQUE_OFF_HI = 5'h15,
    SRC_SUPPLY = 5'h16,
    SRC_FREQ_BELOW_LO = 5'h17
  } sos_src_e;

  // Bit positions inside the internal state vector.
  localparam int IDX_IN0 = 0;
  localparam int IDX_SAFE_OUT = 6;
  localparam int IDX_ERR2 = 7;
  localparam int IDX_ERR3 = 8;
  localparam int IDX_ERR4 = 9;
  localparam int IDX_TORQUE_OFF = 10;
  localparam int IDX_SUPPLY = 11;
  localparam int IDX_FREQ_BELOW = 12;

  // Register byte offsets.
  localparam logic [7:0] ADDR_SEL_A = 8'h00;
  localparam logic [7:0] ADDR_SEL_B = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_CLEAR = 8'h0c;
  localparam logic [7:0] ADDR_ENABLE = 8'h10;
  localparam logic [7:0] ADDR_THRESH = 8'h14;
  localparam logic [7:0] ADDR_STATE = 8'h18;

  // Event bits of the status, clear and enable registers.
  localparam int EV_REJECT_A = 0;
  localparam int EV_REJECT_B = 1;
  localparam int EV_CHANGE_A = 2;
  localparam int EV_CHANGE_B = 3;

  // Fields of the live state register.
  localparam int ST_OUT_A = 0;
  localparam int ST_OUT_B = 1;
  localparam int ST_NOT_MEANINGFUL = 2;
  localparam int ST_IN_LSB = 8;
  localparam int ST_FREQ_LSB = 16;

  // Reset values.
  localparam logic [4:0] SEL_RST = 5'h00;
  localparam logic [3:0] EV_RST = 4'h0;
  localparam logic [15:0] THRESH_RST = 16'h0000;

endpackage

// ===== hw/sos_output_mux.sv
// One state output: source decode, polarity and output register.
`timescale 1ns/1ps
`default_nettype none

module sos_output_mux (
  input wire logic clk,                          // System clock.
  input wire logic rst,                          // Synchronous reset.
  input wire logic [4:0] sel,                    // Source code.
  input wire logic [sos_pkg::STATE_W-1:0] state, // Internal states.
  output logic pin_out                           // Registered output level.
);

  typedef struct packed {
    logic out;
  } sos_mux_s;

  sos_mux_s s_r;
  sos_mux_s s_nxt;

  // Maps a source code to its pin level; unknown codes read as low.
  function automatic logic src_level(input logic [4:0] code,
                                     input logic [sos_pkg::STATE_W-1:0] st);
    logic lvl;
    lvl = 1'b0;
    unique case (code)
      sos_pkg::SRC_NONE: lvl = 1'b0;
      sos_pkg::SRC_IN1_HI: lvl = st[sos_pkg::IDX_IN0];
      sos_pkg::SRC_IN2_HI: lvl = st[sos_pkg::IDX_IN0+1];
      sos_pkg::SRC_IN3_HI: lvl = st[sos_pkg::IDX_IN0+2];
      sos_pkg::SRC_IN4_HI: lvl = st[sos_pkg::IDX_IN0+3];
      sos_pkg::SRC_IN5_HI: lvl = st[sos_pkg::IDX_IN0+4];
      sos_pkg::SRC_IN6_HI: lvl = st[sos_pkg::IDX_IN0+5];
      sos_pkg::SRC_IN1_LO: lvl = ~st[sos_pkg::IDX_IN0];
      sos_pkg::SRC_IN2_LO: lvl = ~st[sos_pkg::IDX_IN0+1];
      sos_pkg::SRC_IN3_LO: lvl = ~st[sos_pkg::IDX_IN0+2];
      sos_pkg::SRC_IN4_LO: lvl = ~st[sos_pkg::IDX_IN0+3];
      sos_pkg::SRC_IN5_LO: lvl = ~st[sos_pkg::IDX_IN0+4];
      sos_pkg::SRC_IN6_LO: lvl = ~st[sos_pkg::IDX_IN0+5];
      sos_pkg::SRC_SAFE_OUT_LO: lvl = ~st[sos_pkg::IDX_SAFE_OUT];
      sos_pkg::SRC_SAFE_OUT_HI: lvl = st[sos_pkg::IDX_SAFE_OUT];
      sos_pkg::SRC_ERR2_HI: lvl = st[sos_pkg::IDX_ERR2];
      sos_pkg::SRC_ERR3_HI: lvl = st[sos_pkg::IDX_ERR3];
      sos_pkg::SRC_ERR4_HI: lvl = st[sos_pkg::IDX_ERR4];
      sos_pkg::SRC_ERR2_LO: lvl = ~st[sos_pkg::IDX_ERR2];
      sos_pkg::SRC_ERR3_LO: lvl = ~st[sos_pkg::IDX_ERR3];
      sos_pkg::SRC_ERR4_LO: lvl = ~st[sos_pkg::IDX_ERR4];
      sos_pkg::SRC_TORQUE_OFF_HI: lvl = st[sos_pkg::IDX_TORQUE_OFF];
      sos_pkg::SRC_SUPPLY: lvl = st[sos_pkg::IDX_SUPPLY];
      sos_pkg::SRC_FREQ_BELOW_LO: lvl = ~st[sos_pkg::IDX_FREQ_BELOW];
      default: lvl = 1'b0;
    endcase
    return lvl;
  endfunction

  // Next output level; high-active sources pass, low-active ones invert.
  always_comb begin
    s_nxt.out = src_level(sel, state);
  end

  // Output register, low after reset.
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pin_out = s_r.out;

endmodule

`default_nettype wire

// ===== verif/sos_props.sv
// Concurrent checks on the ports of the state output selector.
`timescale 1ns/1ps
`default_nettype none

module sos_props #(
  parameter int FREQ_W = 16 // Motor frequency width.
) (
  input wire logic REF_CLK, // Clock.
  input wire logic RST, // Reset.
  input wire logic PSEL, // Select.
  input wire logic PENABLE, // Enable.
  input wire logic PWRITE, // Direction.
  input wire logic [7:0] PADDR, // Address.
  input wire logic PREADY, // Ready.
  input wire logic PSLVERR, // Error.
  input wire logic [5:0] SAFE_IN, // Safe inputs.
  input wire logic SAFETY_OUT_LEVEL, // Safety output.
  input wire logic ERR_CLASS2, // Error class 2.
  input wire logic ERR_CLASS3, // Error class 3.
  input wire logic ERR_CLASS4, // Error class 4.
  input wire logic TORQUE_OFF, // Torque off.
  input wire logic SUPPLY_MONITOR, // Supply monitor.
  input wire logic [FREQ_W-1:0] MOTOR_FREQ, // Frequency.
  input wire logic OPEN_LOOP, // Open loop.
  input wire logic POWER_STAGE_ON, // Power stage.
  input wire logic STATE_OUTPUT_A, // Output A.
  input wire logic STATE_OUTPUT_B, // Output B.
  input wire logic FREQ_NOT_MEANINGFUL, // Compare invalid.
  input wire logic IRQ // Interrupt.
);

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  ////////////////////////////////////////////////////////////////////////////
  // No write and no moving source; four of these cover the input latency.
  sequence quiet;
    !(PSEL && PENABLE && PWRITE) && $stable({SAFE_IN, SAFETY_OUT_LEVEL,
      ERR_CLASS2, ERR_CLASS3, ERR_CLASS4, TORQUE_OFF, SUPPLY_MONITOR,
      MOTOR_FREQ, OPEN_LOOP, POWER_STAGE_ON});
  endsequence

  a_ready_access: assert property (PSEL && PENABLE |-> PREADY)
    else $error("ready missing in access cycle");
  a_ready_only: assert property (PREADY |-> PSEL && PENABLE)
    else $error("ready outside access cycle");
  a_err_unmapped: assert property (PSEL && PENABLE && PADDR > 8'h18 |->
    PSLVERR)
    else $error("unmapped access not flagged");
  a_err_mapped: assert property (PSEL && PENABLE && PADDR <= 8'h18 &&
    PADDR[1:0] == 2'b00 |-> !PSLVERR)
    else $error("mapped access flagged");
  a_reset_quiet: assert property ($past(RST) |->
    !STATE_OUTPUT_A && !STATE_OUTPUT_B && !IRQ && !FREQ_NOT_MEANINGFUL)
    else $error("outputs not low after reset");
  a_invalid_follow: assert property (!$past(RST) |->
    FREQ_NOT_MEANINGFUL == $past(OPEN_LOOP && !POWER_STAGE_ON))
    else $error("invalid flag does not follow power stage");
  a_out_a_steady: assert property (quiet [*4] |->
    $stable(STATE_OUTPUT_A))
    else $error("output A moved without cause");
  a_out_b_steady: assert property (quiet [*4] |->
    $stable(STATE_OUTPUT_B))
    else $error("output B moved without cause");

  // Main scenarios seen at least once.
  c_err: cover property (PSEL && PENABLE && PSLVERR);
  c_irq: cover property ($rose(IRQ));
  c_out_b: cover property ($rose(STATE_OUTPUT_B));

endmodule

bind sos_top sos_props #(.FREQ_W(FREQ_W)) u_props (.REF_CLK(REF_CLK),
  .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR), .SAFE_IN(SAFE_IN),
  .SAFETY_OUT_LEVEL(SAFETY_OUT_LEVEL), .ERR_CLASS2(ERR_CLASS2),
  .ERR_CLASS3(ERR_CLASS3), .ERR_CLASS4(ERR_CLASS4),
  .TORQUE_OFF(TORQUE_OFF), .SUPPLY_MONITOR(SUPPLY_MONITOR),
  .MOTOR_FREQ(MOTOR_FREQ), .OPEN_LOOP(OPEN_LOOP),
  .POWER_STAGE_ON(POWER_STAGE_ON), .STATE_OUTPUT_A(STATE_OUTPUT_A),
  .STATE_OUTPUT_B(STATE_OUTPUT_B),
  .FREQ_NOT_MEANINGFUL(FREQ_NOT_MEANINGFUL), .IRQ(IRQ));

`default_nettype wire

// ===== verif/sos_lamp.sv
// Far-side indicator model that counts rising edges of both outputs.
`timescale 1ns/1ps
`default_nettype none

module sos_lamp (
  input wire logic clk, // Clock.
  input wire logic rst, // Reset.
  input wire logic lamp_a, // Output A.
  input wire logic lamp_b, // Output B.
  output logic [7:0] rises // Rising edges seen.
);
  logic [1:0] last;

  // An indicator only samples; it never drives anything back.
  always @(posedge clk) begin
    if (rst) begin
      rises <= 8'h00;
      last <= 2'b00;
    end else begin
      rises <= rises + 8'(lamp_a & ~last[0]) + 8'(lamp_b & ~last[1]);
      last <= {lamp_b, lamp_a};
    end
  end
endmodule

`default_nettype wire

// ===== verif/tb_state_output_selector.sv
// Self-checking testbench of the state output selector.
`timescale 1ns/1ps
`default_nettype none

module tb_state_output_selector;
  logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr, rises;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] safe_in;
  logic safety, e2, e3, e4, torque, supply, lsa, open_loop, pwr_on;
  logic [15:0] freq;
  logic out_a, out_b, not_meaningful, irq;
  logic [12:0] s;
  logic [15:0] fv [4] = '{16'd99, 16'd100, 16'd150, 16'd0};
  int n_fail, comparisons, i, c, j;

  sos_top #(.FREQ_W(16)) DUT (.REF_CLK(ref_clk), .RST(rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SAFE_IN(safe_in), .SAFETY_OUT_LEVEL(safety), .ERR_CLASS2(e2),
    .ERR_CLASS3(e3), .ERR_CLASS4(e4), .TORQUE_OFF(torque),
    .SUPPLY_MONITOR(supply), .MOTOR_FREQ(freq),
    .LIMITED_SPEED_ASSIGNED(lsa), .OPEN_LOOP(open_loop),
    .POWER_STAGE_ON(pwr_on), .STATE_OUTPUT_A(out_a),
    .STATE_OUTPUT_B(out_b), .FREQ_NOT_MEANINGFUL(not_meaningful),
    .IRQ(irq));
  sos_lamp u_lamp (.clk(ref_clk), .rst(rst), .lamp_a(out_a),
    .lamp_b(out_b), .rises(rises));

  ////////////////////////////////////////////////////////////////////////////
  // Clock at 20 MHz.
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Compares one value and counts it.
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; only the watchdog cuts a wait for ready short.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Expected output level of a source code for a state vector.
  function automatic logic expo(input logic [4:0] c, input logic [12:0] s);
    if (c == 5'h00) return 1'b0;
    if (c <= 5'h06) return s[c - 5'h01];
    if (c <= 5'h0c) return !s[c - 5'h07];
    if (c == 5'h0d) return !s[6];
    if (c == 5'h0e) return s[6];
    if (c <= 5'h11) return s[c - 5'h08];
    if (c <= 5'h14) return !s[c - 5'h0b];
    if (c == 5'h17) return !s[12];
    return s[c - 5'h0b];
  endfunction

  // Ends the run with counts and verdict.
  task end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Cuts a hang short well past the expected run length.
  initial begin
    #2000000;
    n_fail++;
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    c = $urandom(32'hebbf);
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    {safe_in, safety, e2, e3, e4, torque, supply, freq} = 28'h0;
    {lsa, open_loop, pwr_on} = 3'b001;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    for (i = 0; i < 7; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(rd, 32'h0);
      chk(er, 1'b0);
    end
    apb(1'b1, 8'h1c, 32'hffffffff);
    chk(er, 1'b1);
    apb(1'b0, 8'h1c, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    $display("test reset_and_map done");
    for (c = 0; c < 23; c++) begin
      s = 13'($urandom);
      for (j = 0; j < 2; j++) begin
        s[12] = 1'b0;
        apb(1'b1, sos_pkg::ADDR_SEL_A, 32'(c));
        apb(1'b1, sos_pkg::ADDR_SEL_B, 32'(22 - c));
        {supply, torque, e4, e3, e2, safety, safe_in} <= s[11:0];
        repeat (4) @(posedge ref_clk);
        chk(out_a, expo(5'(c), s));
        chk(out_b, expo(5'(22 - c), s));
        apb(1'b0, sos_pkg::ADDR_STATE, 32'h0);
        chk(rd[13:8], s[5:0]);
        s = ~s;
      end
    end
    $display("test all_sources done");
    apb(1'b1, sos_pkg::ADDR_SEL_A, 32'h17);
    apb(1'b0, sos_pkg::ADDR_SEL_A, 32'h0);
    chk(rd, 32'h16);
    apb(1'b1, sos_pkg::ADDR_SEL_B, 32'h1f);
    apb(1'b0, sos_pkg::ADDR_STATUS, 32'h0);
    chk(rd[3:0], 4'hf);
    lsa <= 1'b1;
    apb(1'b1, sos_pkg::ADDR_THRESH, 32'd100);
    apb(1'b1, sos_pkg::ADDR_SEL_A, 32'h17);
    apb(1'b0, sos_pkg::ADDR_SEL_A, 32'h0);
    chk(rd, 32'h17);
    for (i = 0; i < 4; i++) begin
      freq <= fv[i];
      repeat (3) @(posedge ref_clk);
      chk(out_a, !(fv[i] < 16'd100));
    end
    freq <= 16'd150;
    open_loop <= 1'b1;
    pwr_on <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk({not_meaningful, out_a}, 2'b10);
    apb(1'b0, sos_pkg::ADDR_STATE, 32'h0);
    chk({rd[31:16], rd[2]}, 17'h1);
    pwr_on <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk({not_meaningful, out_a}, 2'b01);
    $display("test frequency done");
    apb(1'b1, sos_pkg::ADDR_CLEAR, 32'hf);
    apb(1'b1, sos_pkg::ADDR_SEL_A, 32'h1f);
    apb(1'b1, sos_pkg::ADDR_ENABLE, 32'h1);
    @(posedge ref_clk);
    chk(irq, 1'b1);
    apb(1'b1, sos_pkg::ADDR_ENABLE, 32'h0);
    @(posedge ref_clk);
    chk(irq, 1'b0);
    apb(1'b1, sos_pkg::ADDR_ENABLE, 32'h1);
    apb(1'b1, sos_pkg::ADDR_CLEAR, 32'h1);
    @(posedge ref_clk);
    chk(irq, 1'b0);
    apb(1'b0, sos_pkg::ADDR_CLEAR, 32'h0);
    chk(rd, 32'h0);
    $display("test interrupt done");
    // The indicator clears its count on reset, so it is read before.
    chk(rises != 8'h00, 1'b1);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    apb(1'b0, sos_pkg::ADDR_SEL_A, 32'h0);
    chk(rd, 32'h0);
    chk({out_a, out_b, irq, not_meaningful}, 4'h0);
    $display("test second_reset done");
    end_sim();
  end
endmodule

`default_nettype wire
